// >>> hw/pxc_pkg.sv
package pxc_pkg;

   // ==========================================================
   // function codes (octal numbering of the host instruction)
   // ==========================================================
   localparam logic [3:0] FN_IDLE     = 4'h0;
   localparam logic [3:0] FN_IN_A     = 4'h1;
   localparam logic [3:0] FN_IN_B     = 4'h2;
   localparam logic [3:0] FN_IN_C     = 4'h3;
   localparam logic [3:0] FN_POLL     = 4'h4;
   localparam logic [3:0] FN_LOAD_ADR = 4'h5;
   localparam logic [3:0] FN_MASK     = 4'h6;
   localparam logic [3:0] FN_IRQ_MODE = 4'h7;
   localparam logic [3:0] FN_RD_DATA  = 4'h8;  // octal 10
   localparam logic [3:0] FN_STATUS1  = 4'h9;  // octal 11
   localparam logic [3:0] FN_STATUS2  = 4'hB;  // octal 13
   localparam logic [3:0] FN_OUT_A    = 4'hC;  // octal 14
   localparam logic [3:0] FN_OUT_B    = 4'hD;  // octal 15
   localparam logic [3:0] FN_OUT_C    = 4'hE;  // octal 16
   localparam logic [3:0] FN_CONTROL  = 4'hF;  // octal 17

   // ==========================================================
   // widths and status word layout
   // ==========================================================
   localparam int WORD_W = 16;
   localparam int ADDR_W = 6;
   localparam int CTL_W  = 4;
   localparam int ST_CODE_LSB  = 0;
   localparam int ST_DMA       = 7;
   localparam int ST_CHAN_IE   = 8;
   localparam int ST_CTRL_IE   = 9;
   localparam int ST_ACTIVE    = 10;
   localparam int ST_BUSY      = 11;
   localparam int ST_DONE      = 12;
   localparam int ST_INTR      = 13;
   localparam int ST_SEL_BUSY  = 14;
   localparam int ST_SEL_DONE  = 15;
   localparam int MODE_CHAN_IE = 0;
   localparam int MODE_CTRL_IE = 1;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int CLK_PERIOD_NS  = 10;
   localparam int FUNC_DELAY_NS  = 1000;
   localparam int REARM_NS       = 400;
   localparam int FUNC_DELAY_CYC = (FUNC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REARM_CYC      = (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // types
   // ==========================================================
   typedef enum logic [3:0] {
      PXC_OP_NONE, PXC_OP_IN_A, PXC_OP_IN_B, PXC_OP_IN_C, PXC_OP_POLL,
      PXC_OP_MASK, PXC_OP_OUT_A, PXC_OP_OUT_B, PXC_OP_OUT_C, PXC_OP_CONTROL
   } pxc_op_t;

   typedef struct packed {
      logic                req;
      pxc_op_t             op;
      logic [ADDR_W-1:0]   addr;
      logic [WORD_W-1:0]   data;
   } pxc_bus_cmd_t;

   typedef struct packed {
      logic                ack;
      logic [WORD_W-1:0]   rdata;
      logic                sel_busy;
      logic                sel_done;
   } pxc_bus_rsp_t;

endpackage : pxc_pkg

// >>> hw/pxc_delay_timer.sv
// count-down timer: start loads the count, expired is high once it runs out
module pxc_delay_timer #(
   parameter int CYCLES = 100
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      expired
);
   import pxc_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   if (CYCLES < 1) begin : g_bad
      $error("pxc_delay_timer: CYCLES must be at least 1");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // ==========================================================
   // counter
   // ==========================================================
   assign cnt_d   = start ? CW'(CYCLES) : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
   assign expired = (cnt_q == '0);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule : pxc_delay_timer

// >>> hw/pxc_prio_find.sv
// registered search for the highest priority requester (lowest index wins)
module pxc_prio_find #(
   parameter int N = 16
) (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire logic [N-1:0]              req,
   output logic                           found,
   output logic [pxc_pkg::ADDR_W-1:0]     code
);
   import pxc_pkg::*;

   if (N < 1 || N > (1 << ADDR_W)) begin : g_bad
      $error("pxc_prio_find: N out of range");
   end

   function automatic logic [ADDR_W-1:0] first_set(input logic [N-1:0] v);
      logic [ADDR_W-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--)
         if (v[i])
            r = ADDR_W'(i);
      return r;
   endfunction : first_set

   // ==========================================================
   // result flops
   // ==========================================================
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         found <= 1'b0;
         code  <= '0;
      end
      else
      begin
         found <= |req;
         code  <= first_set(req);
      end
   end

endmodule : pxc_prio_find

// >>> hw/pxc_channel.sv
// Contract
// - function 0 clears busy, done, enables; code keeps controller enable
// - fetch sets busy, clears done next period
// - bus fetch lasts at least one microsecond
// - function 10 returns captured input word
// - functions 2,3 fetch B and C
// - function 4 polls flags, finds interrupter
// - function 4 delayed; function 11 returns result
// - function 5 loads six address bits
// - address load leaves busy, done alone
// - listed codes are delayed bus functions
// - function 6 broadcasts sixteen bit mask
// - mask clears interrupt; rearms after 400 ns
// - functions 14-16 write A, B, C
// - decode 7,10,11,13,17 as documented
// - sixteen controllers, one active at once
// - one channel, device address selects unit
// - function 7 sets the two enables
// - captured data held until next fetch
module pxc_channel #(
   parameter int N_CTRL = 16
) (
   input  wire logic                            clock,
   input  wire logic                            rst_n,
   input  wire logic                            func_valid,
   input  wire logic [3:0]                      func_code,
   input  wire logic [pxc_pkg::WORD_W-1:0]      acc_in,
   output logic                                 rd_valid,
   output logic [pxc_pkg::WORD_W-1:0]           rd_data,
   output logic                                 chan_busy,
   output logic                                 chan_done,
   output logic                                 host_irq,
   input  wire logic                            dma_enable_set,
   output logic                                 dma_enable,
   output pxc_pkg::pxc_bus_cmd_t                bus_cmd,
   input  wire pxc_pkg::pxc_bus_rsp_t           bus_rsp,
   input  wire logic [N_CTRL-1:0]               dev_irq
);
   import pxc_pkg::*;

   if (N_CTRL < 1 || N_CTRL > WORD_W) begin : g_bad
      $error("pxc_channel: N_CTRL must be 1..16");
   end

   typedef enum {ST_IDLE, ST_BUS, ST_HOLD} pxc_state_t;

   // ==========================================================
   // reset release
   // ==========================================================
   logic rst_meta_q;
   logic rst_sync_n;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // ==========================================================
   // function decode
   // ==========================================================
   function automatic pxc_op_t op_of(input logic [3:0] fn);
      pxc_op_t o;
      o = PXC_OP_NONE;
      if (fn == FN_IN_A)         o = PXC_OP_IN_A;
      else if (fn == FN_IN_B)    o = PXC_OP_IN_B;
      else if (fn == FN_IN_C)    o = PXC_OP_IN_C;
      else if (fn == FN_POLL)    o = PXC_OP_POLL;
      else if (fn == FN_MASK)    o = PXC_OP_MASK;
      else if (fn == FN_OUT_A)   o = PXC_OP_OUT_A;
      else if (fn == FN_OUT_B)   o = PXC_OP_OUT_B;
      else if (fn == FN_OUT_C)   o = PXC_OP_OUT_C;
      else if (fn == FN_CONTROL) o = PXC_OP_CONTROL;
      return o;
   endfunction : op_of

   pxc_state_t        state_q;
   pxc_state_t        state_d;
   logic              busy_q;
   logic              done_q;
   logic              chan_ie_q;
   logic              ctrl_ie_q;
   logic              dma_q;
   logic [ADDR_W-1:0] dev_addr_q;
   logic [WORD_W-1:0] mask_q;
   logic [WORD_W-1:0] data_q;
   logic              sel_busy_q;
   logic              sel_done_q;
   logic [ADDR_W-1:0] irq_code_q;
   logic              intr_flag_q;
   logic              holdoff_q;
   logic              rearm_arm_q;
   pxc_bus_cmd_t      cmd_q;

   // one function per request; a new delayed one is refused while active
   pxc_op_t issue_op;
   wire     active     = (state_q != ST_IDLE);
   assign   issue_op   = op_of(func_code);
   wire     is_delayed = (issue_op != PXC_OP_NONE);
   wire     do_delay   = func_valid && is_delayed && !active;
   wire     do_idle    = func_valid && (func_code == FN_IDLE);
   wire     do_load    = func_valid && (func_code == FN_LOAD_ADR) && !active;
   wire     do_mode    = func_valid && (func_code == FN_IRQ_MODE);
   wire     do_rd_data = func_valid && (func_code == FN_RD_DATA);
   wire     do_st1     = func_valid && (func_code == FN_STATUS1);
   wire     do_st2     = func_valid && (func_code == FN_STATUS2);
   wire     do_fetch   = do_delay && (issue_op == PXC_OP_IN_A || issue_op == PXC_OP_IN_B
                                      || issue_op == PXC_OP_IN_C);
   wire     do_mask    = do_delay && (issue_op == PXC_OP_MASK);

   // ==========================================================
   // function delay timer and bus handshake
   // ==========================================================
   logic delay_expired;
   logic rearm_expired;

   pxc_delay_timer #(.CYCLES(FUNC_DELAY_CYC)) u_func_delay (
      .clock   (clock),
      .rst_n   (rst_sync_n),
      .start   (do_delay),
      .expired (delay_expired)
   );

   // completion needs both the bus answer and the least delay
   wire bus_ack_now = (state_q == ST_BUS) && bus_rsp.ack;
   wire finish      = ((state_q == ST_BUS) && bus_rsp.ack && delay_expired)
                      || ((state_q == ST_HOLD) && delay_expired);
   wire finish_abort = do_idle && active;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (do_delay)
               state_d = ST_BUS;
         ST_BUS:
            if (finish_abort || finish)
               state_d = ST_IDLE;
            else if (bus_ack_now)
               state_d = ST_HOLD;
         ST_HOLD:
            if (finish_abort || finish)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // bus command held stable until the bus answers or an abort drops req, one unit at a time
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         cmd_q <= '0;
      else if (do_delay)
         cmd_q <= '{req: 1'b1, op: issue_op, addr: dev_addr_q, data: acc_in};
      else if (bus_ack_now || finish_abort)
         cmd_q.req <= 1'b0;
   end

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // ==========================================================
   // channel busy and done flags
   // ==========================================================
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (do_idle)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (do_delay)
      begin
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end
      else if (finish)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b1;
      end
   end

   // ==========================================================
   // mode, dma, address and mask registers
   // ==========================================================
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         chan_ie_q  <= 1'b0;
         ctrl_ie_q  <= 1'b0;
         dma_q      <= 1'b0;
         dev_addr_q <= '0;
         mask_q     <= '0;
      end
      else
      begin
         if (do_idle)
            chan_ie_q <= 1'b0;
         else if (do_mode)
            chan_ie_q <= acc_in[MODE_CHAN_IE];
         if (do_mode)
            ctrl_ie_q <= acc_in[MODE_CTRL_IE];
         if (dma_enable_set)
            dma_q <= 1'b1;                  // set beats the idle clear
         else if (do_idle)
            dma_q <= 1'b0;
         if (do_load)
            dev_addr_q <= acc_in[ADDR_W-1:0];
         if (do_mask)
            mask_q <= acc_in;
      end
   end

   // ==========================================================
   // captured bus data and poll results
   // ==========================================================
   logic              prio_found;
   logic [ADDR_W-1:0] prio_code;
   wire  [N_CTRL-1:0] live_irq = dev_irq & ~mask_q[N_CTRL-1:0];

   pxc_prio_find #(.N(N_CTRL)) u_prio (
      .clock (clock),
      .rst_n (rst_sync_n),
      .req   (live_irq),
      .found (prio_found),
      .code  (prio_code)
   );

   wire poll_ack = bus_ack_now && (cmd_q.op == PXC_OP_POLL);
   wire in_ack   = bus_ack_now && (cmd_q.op == PXC_OP_IN_A || cmd_q.op == PXC_OP_IN_B
                                   || cmd_q.op == PXC_OP_IN_C);

   // input data is kept until the next fetch answers
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         data_q     <= '0;
         sel_busy_q <= 1'b0;
         sel_done_q <= 1'b0;
         irq_code_q <= '0;
      end
      else
      begin
         if (in_ack)
            data_q <= bus_rsp.rdata;
         if (poll_ack)
         begin
            sel_busy_q <= bus_rsp.sel_busy;
            sel_done_q <= bus_rsp.sel_done;
            irq_code_q <= prio_code;
         end
      end
   end

   // ==========================================================
   // controller interrupt flag with rearm holdoff after a mask
   // ==========================================================
   wire mask_finish = finish && (cmd_q.op == PXC_OP_MASK);

   pxc_delay_timer #(.CYCLES(REARM_CYC)) u_rearm (
      .clock   (clock),
      .rst_n   (rst_sync_n),
      .start   (mask_finish),
      .expired (rearm_expired)
   );

   wire rearm_done = rearm_arm_q && rearm_expired;

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         holdoff_q   <= 1'b0;
         rearm_arm_q <= 1'b0;
         intr_flag_q <= 1'b0;
      end
      else
      begin
         if (do_mask)
            holdoff_q <= 1'b1;
         else if (rearm_done || finish_abort)
            holdoff_q <= 1'b0;
         rearm_arm_q <= mask_finish || (rearm_arm_q && !rearm_expired);
         if (do_mask)
            intr_flag_q <= 1'b0;
         else if (!holdoff_q)
            intr_flag_q <= ctrl_ie_q && prio_found;
      end
   end

   // ==========================================================
   // read answers and status words
   // ==========================================================
   function automatic logic [WORD_W-1:0] status_word(input logic [ADDR_W-1:0] low);
      logic [WORD_W-1:0] w;
      w = '0;
      w[ST_CODE_LSB +: ADDR_W] = low;
      w[ST_DMA]      = dma_q;
      w[ST_CHAN_IE]  = chan_ie_q;
      w[ST_CTRL_IE]  = ctrl_ie_q;
      w[ST_ACTIVE]   = active;
      w[ST_BUSY]     = busy_q;
      w[ST_DONE]     = done_q;
      w[ST_INTR]     = intr_flag_q;
      w[ST_SEL_BUSY] = sel_busy_q;
      w[ST_SEL_DONE] = sel_done_q;
      return w;
   endfunction : status_word

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end
      else
      begin
         rd_valid <= do_rd_data || do_st1 || do_st2;
         if (do_rd_data)
            rd_data <= data_q;
         else if (do_st1)
            rd_data <= status_word(irq_code_q);
         else if (do_st2)
            rd_data <= status_word(dev_addr_q);
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign chan_busy  = busy_q;
   assign chan_done  = done_q;
   assign dma_enable = dma_q;
   assign bus_cmd    = cmd_q;
   assign host_irq   = (done_q && chan_ie_q) || intr_flag_q;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);

   logic [7:0] act_cnt_q;
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         act_cnt_q <= '0;
      else if (do_delay)
         act_cnt_q <= '0;
      else if (active && act_cnt_q != 8'hFF)
         act_cnt_q <= act_cnt_q + 8'h01;
   end

   AST_FETCH_FLAGS: assert property (do_fetch |=> busy_q && !done_q)
      else $error("fetch did not set busy and clear done");
   AST_MIN_DELAY: assert property (finish |-> act_cnt_q >= 8'(FUNC_DELAY_CYC - 1))
      else $error("delayed function finished too early");
   AST_IDLE_CLEARS: assert property (do_idle && !dma_enable_set
         |=> !busy_q && !done_q && !chan_ie_q && !dma_q)
      else $error("idle left flags set");
   AST_ADDR_LOAD: assert property (do_load |=> dev_addr_q == $past(acc_in[ADDR_W-1:0]))
      else $error("device address not loaded");
   AST_ADDR_FLAGS: assert property (do_load |=> $stable(busy_q) && $stable(done_q))
      else $error("address load changed flags");
   AST_READ_DATA: assert property (do_rd_data |=> rd_valid && rd_data == $past(data_q))
      else $error("read data answer wrong");
   AST_MASK_CLEAR: assert property (do_mask |=> !intr_flag_q && mask_q == $past(acc_in))
      else $error("mask did not clear interrupt flag");
   AST_MODE_SET: assert property (do_mode && !finish
         |=> chan_ie_q == $past(acc_in[MODE_CHAN_IE]) && $stable(busy_q))
      else $error("interrupt mode not applied");
   AST_DONE_AFTER_ACK: assert property (finish && !do_idle |=> done_q && !busy_q)
      else $error("done not set on completion");

endmodule : pxc_channel

// >>> tb/pxc_chassis_model.sv
// chassis side: slots with A, B, C registers, answering after ack_delay cycles
module pxc_chassis_model (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [7:0]            ack_delay,
   input  wire pxc_pkg::pxc_bus_cmd_t bus_cmd,
   output pxc_pkg::pxc_bus_rsp_t      bus_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import pxc_pkg::*;

   // ============
   // slot storage and answer timing
   // ============
   logic [WORD_W-1:0] regs_q [16][3];
   logic [7:0]        wait_q;
   wire  [3:0]        slot = bus_cmd.addr[3:0];
   wire               hit  = bus_cmd.req && !bus_rsp.ack && wait_q >= ack_delay;

   // idle data lines toggle so a stale word is never mistaken for an answer
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q  <= 8'h00;
         bus_rsp <= '0;
      end
      else
      begin
         bus_rsp.ack   <= hit;
         bus_rsp.rdata <= ~bus_rsp.rdata;
         wait_q        <= (bus_cmd.req && !hit) ? wait_q + 8'h01 : 8'h00;
         if (hit)
         begin
            case (bus_cmd.op)
               PXC_OP_IN_A, PXC_OP_IN_B, PXC_OP_IN_C:
                  bus_rsp.rdata <= regs_q[slot][bus_cmd.op - PXC_OP_IN_A];
               PXC_OP_OUT_A, PXC_OP_OUT_B, PXC_OP_OUT_C:
                  regs_q[slot][bus_cmd.op - PXC_OP_OUT_A] <= bus_cmd.data;
               PXC_OP_POLL:
                  {bus_rsp.sel_busy, bus_rsp.sel_done} <= regs_q[slot][0][15:14];
               default:;
            endcase
         end
      end
   end
endmodule : pxc_chassis_model

// >>> tb/pxc_channel_tb.sv
module pxc_channel_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pxc_pkg::*;

   // ============
   // stimulus and observed signals
   // ============
   logic               clock = 1'b0;
   logic               rst_n = 1'b0;
   logic               func_valid = 1'b0;
   logic [3:0]         func_code = 4'h0;
   logic [15:0]        acc_in = 16'h0000;
   logic               dma_enable_set = 1'b0;
   logic [15:0]        dev_irq = 16'h0000;
   logic [7:0]         ack_delay = 8'h00;
   logic               rd_valid, chan_busy, chan_done, host_irq, dma_enable;
   logic [15:0]        rd_data, d;
   pxc_bus_cmd_t       bus_cmd;
   pxc_bus_rsp_t       bus_rsp;
   int                 n_errors = 0;
   int                 samples_checked = 0;
   logic [15:0]        wv [3] = '{16'h8A51, 16'h1234, 16'hBEEF};

   always #5 clock = ~clock;

   pxc_channel pxc_channel_i (.clock(clock), .rst_n(rst_n), .func_valid(func_valid),
      .func_code(func_code), .acc_in(acc_in), .rd_valid(rd_valid), .rd_data(rd_data),
      .chan_busy(chan_busy), .chan_done(chan_done), .host_irq(host_irq),
      .dma_enable_set(dma_enable_set), .dma_enable(dma_enable), .bus_cmd(bus_cmd),
      .bus_rsp(bus_rsp), .dev_irq(dev_irq));

   pxc_chassis_model pxc_chassis_model_i (.clock(clock), .rst_n(rst_n),
      .ack_delay(ack_delay), .bus_cmd(bus_cmd), .bus_rsp(bus_rsp));

   // ============
   // host side tasks
   // ============
   task automatic end_sim;
      if (n_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle request strobe, driven between edges
   task automatic issue(input logic [3:0] code, input logic [15:0] acc);
      @(negedge clock);
      func_valid = 1'b1;
      func_code  = code;
      acc_in     = acc;
      @(negedge clock);
      func_valid = 1'b0;
   endtask : issue

   // delayed function: handshake plus minimum duration
   task automatic run(input logic [3:0] code, input logic [15:0] acc, input int ackd);
      int n = 1;
      ack_delay = 8'(ackd);
      issue(code, acc);
      chk({chan_busy, chan_done}, 2'b10);
      while (!chan_done && n < 2000)
      begin
         @(negedge clock);
         n++;
      end
      chk({chan_busy, chan_done}, 2'b01);
      chk(16'(n >= FUNC_DELAY_CYC && n > ackd), 16'h0001);
   endtask : run

   task automatic rd(input logic [3:0] code, output logic [15:0] q);
      int i = 0;
      issue(code, 16'h0000);
      while (rd_valid !== 1'b1 && i < 4)
      begin
         @(negedge clock);
         i++;
      end
      chk(16'(i < 4), 16'h0001);
      q = rd_data;
   endtask : rd

   // ============
   // test sequence
   // ============
   initial
   begin
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      chk({chan_busy, chan_done, host_irq, dma_enable}, 4'h0);
      issue(FN_LOAD_ADR, 16'hFFC5);
      chk({chan_busy, chan_done}, 2'b00);
      rd(FN_STATUS2, d);
      chk(d[5:0], 6'h05);
      foreach (wv[k]) run(4'(FN_OUT_A + k), wv[k], 2);
      // slow answer for C stretches past the minimum delay, B's stays within it
      foreach (wv[k])
      begin
         run(4'(FN_IN_A + k), 16'h0000, k * 60);
         rd(FN_RD_DATA, d);
         chk(d, wv[k]);
      end
      issue(FN_IRQ_MODE, 16'h0001);
      chk({chan_busy, chan_done, host_irq}, 3'b011);
      run(FN_CONTROL, 16'h0003, 5);
      rd(FN_RD_DATA, d);
      chk(d, wv[2]);
      // slots 3 and 9 request, lowest index expected
      dev_irq = 16'h0208;
      issue(FN_IRQ_MODE, 16'h0002);
      run(FN_POLL, 16'h0000, 3);
      rd(FN_STATUS1, d);
      chk(d[5:0], 6'h03);
      chk({d[ST_SEL_BUSY], d[ST_SEL_DONE], d[ST_CTRL_IE], d[ST_CHAN_IE], d[ST_INTR],
           host_irq}, 6'b101011);
      run(FN_MASK, 16'h0008, 2);
      repeat (35) @(negedge clock);
      chk(host_irq, 1'b0);
      repeat (10) @(negedge clock);
      chk(host_irq, 1'b1);
      run(FN_MASK, 16'h0208, 2);
      repeat (50) @(negedge clock);
      chk(host_irq, 1'b0);
      // idle aborts a fetch in flight and drops the dma enable
      dma_enable_set = 1'b1;
      @(negedge clock);
      dma_enable_set = 1'b0;
      chk(dma_enable, 1'b1);
      ack_delay = 8'hC8;
      issue(FN_IN_A, 16'h0000);
      issue(FN_IDLE, 16'h0000);
      chk({chan_busy, chan_done, dma_enable, host_irq, bus_cmd.req}, 5'h00);
      rd(FN_STATUS1, d);
      chk({d[ST_DONE:ST_ACTIVE], d[ST_CHAN_IE], d[ST_DMA]}, 5'h00);
      end_sim();
   end

   // hang guard, far beyond the roughly 1200 cycles the sequence needs
   initial
   begin
      #100000;
      n_errors++;
      end_sim();
   end
endmodule : pxc_channel_tb
